//--- sapm_top.sv
`include "sapm_consts.svh"
// Function
// - mode register steers ports 3, 10, 11
// - only P34-36, P100-107, P110-113 affected
// - byte writes only; reads return undefined
// - bits 3 to 7 always zero
// - width code decodes A1-A4 up to A1-A15
// - program counter upper 8 bits zero
// - bit 23 sign-extends into upper bits
// - nothing external until expansion mode set
module sapm_top
  import sapm_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port latches from port logic
  input  wire logic [2:0]  port3_latch,
  input  wire logic [7:0]  port10_latch,
  input  wire logic [3:0]  port11_latch,
  // CPU address in
  input  wire logic [23:0] phys_addr,
  input  wire logic [31:0] pc_in,
  // Pin side
  output logic [2:0]       port3_out,
  output logic [7:0]       port10_out,
  output logic [3:0]       port11_out,
  output logic [14:0]      sep_addr_active,
  output logic [31:0]      cpu_addr,
  output logic [31:0]      pc_addr
);
  // --------------------------------------------------------------------------
  // Register access
  // --------------------------------------------------------------------------
  logic [7:0]  mode_reg;
  logic [7:0]  exp_reg;
  logic [31:0] rdata_next;
  logic        wr_cyc;
  logic        byte_only;

  sapm_sel_if sel ();

  assign wr_cyc    = psel && penable && pwrite;
  // Only a lone low-lane strobe is a legal 8-bit write
  assign byte_only = (pstrb == 4'h1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= `SAPM_MODE_RST;
    else if (wr_cyc && paddr == `SAPM_OFS_MODE && byte_only)
      mode_reg <= {5'h00, pwdata[`SAPM_SEL_W-1:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      exp_reg <= `SAPM_EXP_RST;
    else if (wr_cyc && paddr == `SAPM_OFS_EXPMODE)
      exp_reg <= {4'h0, pwdata[3:0]};
  end

  always_comb
  begin
    unique case (paddr)
      `SAPM_OFS_MODE:    rdata_next = `SAPM_UNDEF_READ;
      `SAPM_OFS_EXPMODE: rdata_next = {24'h000000, exp_reg};
      `SAPM_OFS_STATUS:  rdata_next = {17'h00000, sel.pin_enable};
      default:           rdata_next = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: every setup cycle is answered in the access cycle after it
  logic setup_cyc;
  logic addr_mode;
  logic addr_exp;
  logic addr_status;
  logic addr_known;
  logic bad_write;

  assign setup_cyc   = psel && !penable;
  assign addr_mode   = (paddr == `SAPM_OFS_MODE);
  assign addr_exp    = (paddr == `SAPM_OFS_EXPMODE);
  assign addr_status = (paddr == `SAPM_OFS_STATUS);
  assign addr_known  = addr_mode || addr_exp || addr_status;
  // Status is read-only and the mode register takes only a lone low-lane byte
  assign bad_write   = pwrite && ((addr_mode && !byte_only) || addr_status);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'h0;
    else
      pready <= setup_cyc;
  end

  // Read data is zero outside the answer, so no stale value lingers on the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_cyc && !pwrite)
      prdata <= rdata_next;
    else
      prdata <= 32'h0000_0000;
  end

  // Unmapped offsets and refused writes answer at once with an error, never a wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'h0;
    else
      pslverr <= setup_cyc && (!addr_known || bad_write);
  end

  // --------------------------------------------------------------------------
  // Pin select
  // --------------------------------------------------------------------------
  assign sel.width_sel    = mode_reg[2:0];
  assign sel.expansion_on = exp_reg[`SAPM_EXP_EN_BIT];

  sapm_decode u_dec (.s(sel));

  // Address bits go out through a registered mux; other pins stay with the port latch. lets
  // us skip glitch guarding: software parks the latch at 0 first.
  // Port 11 carries A1 to A4
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port11_out <= 4'h0;
    else
      for (int i = 0; i < `SAPM_P11_W; i++)
        port11_out[i] <= sel.pin_enable[i] ? phys_addr[i+1] : port11_latch[i];
  end

  // Port 10 carries A5 to A12
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port10_out <= 8'h00;
    else
      for (int i = 0; i < `SAPM_P10_W; i++)
        port10_out[i] <= sel.pin_enable[i+4] ? phys_addr[i+5] : port10_latch[i];
  end

  // Port 3 carries A13 to A15
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port3_out <= 3'h0;
    else
      for (int i = 0; i < `SAPM_P3_W; i++)
        port3_out[i] <= sel.pin_enable[i+12] ? phys_addr[i+13] : port3_latch[i];
  end

  // Copy of which address lines are live, so the external device can mask the window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sep_addr_active <= 15'h0000;
    else
      sep_addr_active <= sel.pin_enable;
  end

  // --------------------------------------------------------------------------
  // Address space images
  // --------------------------------------------------------------------------
  // Every 16 MB image of the physical space folds onto the same bit 23 copy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_addr <= 32'h0000_0000;
    else
      cpu_addr <= {{8{phys_addr[23]}}, phys_addr};
  end

  // Program space is one flat 16 MB run from zero, so the top byte is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_addr <= 32'h0000_0000;
    else
      pc_addr <= {8'h00, pc_in[23:0]};
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // The pins follow the enable as it stood one edge before they are looked at
  logic exp_on;

  assign exp_on = exp_reg[`SAPM_EXP_EN_BIT];

  // Register contents
  chk_mode_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg[7:3] == 5'h00) else $error("mode register high bits set");
  chk_mode_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cyc && addr_mode && byte_only |=> mode_reg[2:0] == $past(pwdata[2:0]))
    else $error("byte write to mode register lost");
  chk_wide_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cyc && paddr == `SAPM_OFS_MODE && pstrb != 4'h1 |=> $stable(mode_reg))
    else $error("non-byte write changed mode");
  chk_exp_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cyc && addr_exp |=> exp_reg == {4'h0, $past(pwdata[3:0])})
    else $error("expansion register write lost");

  // Bus answers: one pulse per transfer, error only alongside it
  chk_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("setup cycle not answered");
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held past one cycle");
  chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  chk_wide_write_err: assert property (@(posedge pclk) disable iff (!presetn)
    setup_cyc && pwrite && addr_mode && !byte_only |=> pslverr)
    else $error("wide mode write not refused");
  chk_byte_write_ok: assert property (@(posedge pclk) disable iff (!presetn)
    setup_cyc && pwrite && addr_mode && byte_only |=> !pslverr)
    else $error("byte mode write refused");
  chk_read_undef: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == `SAPM_OFS_MODE |=> prdata == 32'h0)
    else $error("mode register read leaked state");
  chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_cyc && !pwrite && addr_status |=> prdata == {17'h00000, sep_addr_active})
    else $error("status read differs from pins");

  // Which address lines reach the pins
  chk_no_exp_ports: assert property (@(posedge pclk) disable iff (!presetn)
    !exp_on |=> sep_addr_active == 15'h0000)
    else $error("address pins active outside expansion");
  chk_idle_latches: assert property (@(posedge pclk) disable iff (!presetn)
    !exp_on |=> {port3_out, port10_out, port11_out} ==
    $past({port3_latch, port10_latch, port11_latch}))
    else $error("port latch not passed through");
  chk_code_zero: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg[2:0] == 3'h0 |=> sep_addr_active == 15'h0000)
    else $error("code 000 drove pins");
  chk_reserved_code: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg[2:0] == 3'h1 |=> sep_addr_active == 15'h0000)
    else $error("reserved code drove pins");
  chk_width_32b: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h2 |=> sep_addr_active == 15'h000F)
    else $error("32 byte window lines wrong");
  chk_width_512b: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h3 |=> sep_addr_active == 15'h00FF)
    else $error("512 byte window lines wrong");
  chk_sel_drive: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h4 |=> sep_addr_active == 15'h0FFF)
    else $error("8 KB window wrong");
  chk_width_16k: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h5 |=> sep_addr_active == 15'h1FFF)
    else $error("16 KB window lines wrong");
  chk_width_32k: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h6 |=> sep_addr_active == 15'h3FFF)
    else $error("32 KB window lines wrong");
  chk_width_64k: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h7 |=> sep_addr_active == 15'h7FFF)
    else $error("64 KB window lines wrong");

  // Pin contents per window
  chk_small_width: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h2 |=>
    port10_out == $past(port10_latch) && port11_out == $past(phys_addr[4:1]))
    else $error("32 byte window wrong");
  chk_mid_width: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h3 |=>
    port10_out == {$past(port10_latch[7:4]), $past(phys_addr[8:5])})
    else $error("512 byte window wrong");
  chk_p3_kept: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h4 |=> port3_out == $past(port3_latch))
    else $error("port 3 taken by 8 KB window");
  chk_p10_full: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h4 |=> port10_out == $past(phys_addr[12:5]))
    else $error("A5-A12 missing");
  chk_p3_partial: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h5 |=>
    port3_out == {$past(port3_latch[2:1]), $past(phys_addr[13])})
    else $error("16 KB window wrong");
  chk_full_width: assert property (@(posedge pclk) disable iff (!presetn)
    exp_on && mode_reg[2:0] == 3'h7 |=> port3_out == $past(phys_addr[15:13]))
    else $error("A13-A15 missing");

  // Address space images
  chk_sign_ext: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 cpu_addr[31:24] == {8{$past(phys_addr[23])}})
    else $error("bit 23 not extended");
  chk_sign_low: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 cpu_addr[23:0] == $past(phys_addr))
    else $error("physical address not passed");
  chk_pc_top: assert property (@(posedge pclk) disable iff (!presetn)
    pc_addr[31:24] == 8'h00) else $error("program counter top nonzero");
  chk_pc_low: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pc_addr[23:0] == $past(pc_in[23:0]))
    else $error("program counter low bits lost");
endmodule : sapm_top

//--- sapm_consts.svh
`ifndef SAPM_CONSTS_SVH
`define SAPM_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------------------
`define SAPM_OFS_MODE     12'h000
`define SAPM_OFS_EXPMODE  12'h004
`define SAPM_OFS_ADDR     12'h008
`define SAPM_OFS_STATUS   12'h00C
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SAPM_SEL_W        3
`define SAPM_MODE_RST     8'h00
`define SAPM_EXP_RST      8'h00
`define SAPM_EXP_EN_BIT   3
`define SAPM_UNDEF_READ   32'h0000_0000
// ----------------------------------------------------------------------------
// Pin counts per port
// ----------------------------------------------------------------------------
`define SAPM_P3_W         3
`define SAPM_P10_W        8
`define SAPM_P11_W        4
`endif

//--- sapm_pkg.sv
package sapm_pkg;
  typedef enum logic [2:0]
  {
    SAPM_W_NONE = 3'h0,
    SAPM_W_32B  = 3'h2,
    SAPM_W_512B = 3'h3,
    SAPM_W_8K   = 3'h4,
    SAPM_W_16K  = 3'h5,
    SAPM_W_32K  = 3'h6,
    SAPM_W_64K  = 3'h7
  } sapm_width_t;
endpackage : sapm_pkg

//--- sapm_sel_if.sv
interface sapm_sel_if;
  logic [2:0]  width_sel;
  logic        expansion_on;
  logic [14:0] pin_enable;
  modport ctrl (output width_sel, output expansion_on, input pin_enable);
  modport dec  (input width_sel, input expansion_on, output pin_enable);
endinterface : sapm_sel_if

//--- sapm_decode.sv
`include "sapm_consts.svh"
module sapm_decode
  import sapm_pkg::*;
(
  sapm_sel_if.dec s
);
  logic [14:0] en;
  always_comb
  begin
    en = 15'h0000;
    if (s.expansion_on)
    begin
      unique case (s.width_sel)
        SAPM_W_32B:  en = 15'h000F;
        SAPM_W_512B: en = 15'h00FF;
        SAPM_W_8K:   en = 15'h0FFF;
        SAPM_W_16K:  en = 15'h1FFF;
        SAPM_W_32K:  en = 15'h3FFF;
        SAPM_W_64K:  en = 15'h7FFF;
        default:     en = 15'h0000;
      endcase
    end
  end
  assign s.pin_enable = en;
endmodule : sapm_decode

//--- sapm_ext_mem.sv
module sapm_ext_mem
(
  // Pins seen by the external device
  input  wire logic [2:0]  port3_out,
  input  wire logic [7:0]  port10_out,
  input  wire logic [3:0]  port11_out,
  input  wire logic [14:0] sep_addr_active,
  // Address as decoded by the device
  output logic      [15:0] seen_addr
);
  // Pins left in port mode carry latch data, so the device ignores them
  always_comb seen_addr = {{port3_out, port10_out, port11_out} & sep_addr_active, 1'b0};
endmodule : sapm_ext_mem

//--- testbench.sv
`include "sapm_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cpu_addr, pc_addr, pc_in, rd, e;
  logic [3:0]  pstrb, port11_latch, port11_out;
  logic [2:0]  port3_latch, port3_out;
  logic [7:0]  port10_latch, port10_out;
  logic [23:0] phys_addr;
  logic [14:0] sep_addr_active, msk, pins;
  logic [15:0] seen_addr;
  int          failures, tests_run, seed, n;
  int          wtab[8] = '{0, 0, 4, 8, 12, 13, 14, 15};

  sapm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port3_latch(port3_latch),
    .port10_latch(port10_latch), .port11_latch(port11_latch), .phys_addr(phys_addr),
    .pc_in(pc_in), .port3_out(port3_out), .port10_out(port10_out),
    .port11_out(port11_out), .sep_addr_active(sep_addr_active), .cpu_addr(cpu_addr),
    .pc_addr(pc_addr));
  sapm_ext_mem mem (.port3_out(port3_out), .port10_out(port10_out),
    .port11_out(port11_out), .sep_addr_active(sep_addr_active), .seen_addr(seen_addr));

  initial
  begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end

  task final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 0; pready !== 1'b1 && i < 16; i++) @(posedge pclk);
    if (i == 16)
    begin
      failures++;
      final_report();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  initial
  begin
    seed = 32'h1bc8;
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {port3_latch, port10_latch, port11_latch, phys_addr, pc_in} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SAPM_OFS_STATUS, 32'h0, 4'h0);
    chk(rd, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      phys_addr <= 24'($random(seed));
      pc_in <= $random(seed);
      {port3_latch, port10_latch, port11_latch} <= 15'($random(seed));
      e = ((c / 8) << 3) | ($random(seed) & 7);
      apb(1, `SAPM_OFS_EXPMODE, 32'h0, 4'h1);
      apb(1, `SAPM_OFS_MODE, ($random(seed) & ~32'h7) | (c % 8), 4'h1);
      chk(er, 0);
      apb(1, `SAPM_OFS_MODE, (c % 8) ^ 7, 4'hF);
      chk(er, 1);
      apb(1, `SAPM_OFS_STATUS, 32'h0, 4'hF);
      chk(er, 1);
      apb(1, `SAPM_OFS_EXPMODE, e, 4'h1);
      apb(0, `SAPM_OFS_EXPMODE, 32'h0, 4'h0);
      chk(rd, e);
      apb(0, `SAPM_OFS_MODE, 32'h0, 4'h0);
      chk(rd, `SAPM_UNDEF_READ);
      apb(0, 12'h010, 32'h0, 4'h0);
      chk(er, 1);
      chk(rd, 32'h0);
      repeat (2) @(posedge pclk);
      #1;
      n = (c >= 8) ? wtab[c % 8] : 0;
      msk = 15'((1 << n) - 1);
      pins = ({port3_latch, port10_latch, port11_latch} & ~msk) | (phys_addr[15:1] & msk);
      chk({port3_out, port10_out, port11_out}, pins);
      chk(sep_addr_active, msk);
      chk(seen_addr, {phys_addr[15:1] & msk, 1'b0});
      chk(cpu_addr, {{8{phys_addr[23]}}, phys_addr});
      chk(pc_addr, {8'h00, pc_in[23:0]});
      apb(0, `SAPM_OFS_STATUS, 32'h0, 4'h0);
      chk(rd, msk);
    end
    final_report();
  end
endmodule : testbench
